// *** panel_model.sv ***
// Behavioural front panel: loops, buttons and external release input
`timescale 1ns/1ps
`default_nettype none

module panel_model
    import sequencer_pkg::*;
(
    // Clock
    input wire logic clk,
    // Pin levels towards the sequencer
    output logic [N_IN-1:0] pins
);
    initial pins = '0;

    // ------------------------------------------------------------
    // Contact changes
    // ------------------------------------------------------------
    // Real contacts chatter; bursts stay far below the debounce time
    task automatic set(input int idx, input logic v);
        repeat (3) begin
            @(posedge clk);
            pins[idx] <= v;
            repeat (5) @(posedge clk);
            pins[idx] <= ~v;
        end
        @(posedge clk);
        pins[idx] <= v;
    endtask : set
endmodule : panel_model
`default_nettype wire

// *** sequencer_pkg.sv ***
// Constants and types for the suppression release sequencer
package sequencer_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES_DEF = TICK_US * 1000 * 1000 / CLK_PERIOD_PS;
    localparam int MS_W = 15;
    localparam int WARN_MS = 15000;
    localparam int REWARN_MS = 20000;
    localparam int HOLD_MS = 5000;
    localparam int REL2_SHORT_MS = 5000;
    localparam int REL2_LONG_MS = 10000;
    localparam int DEBOUNCE_MS = 20;
    localparam int BLINK_MS = 250;
    localparam logic [MS_W-1:0] WARN_TICKS =
        MS_W'(WARN_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] REWARN_TICKS =
        MS_W'(REWARN_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] HOLD_TICKS =
        MS_W'(HOLD_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] REL2_SHORT_TICKS =
        MS_W'(REL2_SHORT_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] REL2_LONG_TICKS =
        MS_W'(REL2_LONG_MS * 1000 / TICK_US);
    localparam int DB_W = 5;
    localparam logic [DB_W-1:0] DB_TICKS =
        DB_W'(DEBOUNCE_MS * 1000 / TICK_US);
    localparam int BL_W = 8;
    localparam logic [BL_W-1:0] BLINK_TICKS =
        BL_W'(BLINK_MS * 1000 / TICK_US);

    // ------------------------------------------------------------
    // Input bit positions after synchronising
    // ------------------------------------------------------------
    localparam int IN_L1_SHORT = 0;
    localparam int IN_L1_OPEN = 1;
    localparam int IN_L2_SHORT = 2;
    localparam int IN_L2_OPEN = 3;
    localparam int IN_L2_FIRE = 4;
    localparam int IN_EXT_SHORT = 5;
    localparam int IN_EXT_OPEN = 6;
    localparam int IN_EXT_PRESS = 7;
    localparam int IN_BTN_A = 8;
    localparam int IN_BTN_B = 9;
    localparam int IN_MUTE = 10;
    localparam int IN_RESET = 11;
    localparam int N_IN = 12;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
    localparam logic [1:0] ROLE_EITHER = 2'h0;
    localparam logic [1:0] ROLE_L1_REL = 2'h1;
    localparam logic [1:0] ROLE_L2_REL = 2'h2;
    localparam logic [1:0] ROLE_DOUBLE = 2'h3;
    localparam int CFG_W = 5;

    typedef struct packed {
        logic [1:0] role;
        logic rel2_long;
        logic rel2_en;
        logic auto_en;
    } cfg_t;

    localparam cfg_t CFG_RESET = cfg_t'(5'h00);

    typedef enum logic [1:0] {PH_IDLE, PH_WARN, PH_FIRED} phase_t;

    typedef struct packed {
        logic alarm_led;
        logic activated_led;
        logic fault_led;
        logic buzzer;
        logic sounder;
        logic shutdown;
        logic release1;
    } outs_t;

endpackage : sequencer_pkg

// *** suppression_release_sequencer.sv ***
// Fire suppression panel release sequencer with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none

module suppression_release_sequencer
    import sequencer_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Loop and external input monitors
    input wire logic loop1_short,
    input wire logic loop1_open,
    input wire logic loop2_short,
    input wire logic loop2_open,
    input wire logic loop2_fire,
    input wire logic ext_short,
    input wire logic ext_open,
    input wire logic ext_press,
    // Front buttons
    input wire logic rel_btn_a,
    input wire logic rel_btn_b,
    input wire logic mute_button,
    input wire logic reset_btn,
    // Indicators and outputs
    output logic alarm_led,
    output logic activated_led,
    output logic fault_led,
    output logic buzzer,
    output logic sounder,
    output logic shutdown,
    output logic release_out
);

    localparam int TICK_W = $clog2(TICK_CYCLES);

    typedef struct packed {
        logic [N_IN-1:0] s1;
        logic [N_IN-1:0] s2;
        logic [N_IN-1:0] db;
        logic [N_IN-1:0] db_prev;
        logic [N_IN-1:0][DB_W-1:0] dbc;
        logic [TICK_W-1:0] tick_cnt;
        logic tick;
        logic [BL_W-1:0] blink_cnt;
        logic blink;
        phase_t phase;
        logic [MS_W-1:0] warn;
        logic [MS_W-1:0] hold;
        logic hold_done;
        logic holding;
        logic [MS_W-1:0] rel2_cnt;
        logic rel2_fired;
        logic released;
        logic alarm;
        logic fault;
        logic lhw_trip;
        logic muted;
        cfg_t cfg;
        logic wr_pend;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
        outs_t outs;
    } st_t;

    st_t q;
    st_t d;

    logic [N_IN-1:0] raw_in;
    logic l1_fire;
    logic l2_fire;
    logic any_fire;
    logic rel_fire;
    logic fault_cause;
    logic both_held;
    logic mute_edge;
    logic rst_edge;
    logic rst_ok;
    logic [15:0] status;

    // ------------------------------------------------------------
    // Input decode
    // ------------------------------------------------------------
    function automatic logic role_fire(input logic [1:0] role,
                                       input logic f1,
                                       input logic f2);
        logic r;
        r = 1'b0;
        unique case (role)
            ROLE_EITHER: r = f1 | f2;
            ROLE_L1_REL: r = f1;
            ROLE_L2_REL: r = f2;
            ROLE_DOUBLE: r = f1 & f2;
        endcase
        return r;
    endfunction : role_fire

    assign raw_in = {reset_btn, mute_button, rel_btn_b, rel_btn_a,
                     ext_press, ext_open, ext_short, loop2_fire,
                     loop2_open, loop2_short, loop1_open, loop1_short};

    assign l1_fire = q.db[IN_L1_SHORT];
    // Loop two detector contact; short or open is a fault
    assign l2_fire = q.db[IN_L2_FIRE] & ~q.db[IN_L2_SHORT]
                     & ~q.db[IN_L2_OPEN];
    assign any_fire = l1_fire | l2_fire;
    assign rel_fire = role_fire(q.cfg.role, l1_fire, l2_fire);
    assign fault_cause = q.db[IN_L1_OPEN] | q.db[IN_L2_SHORT]
                         | q.db[IN_L2_OPEN] | q.db[IN_EXT_SHORT]
                         | q.db[IN_EXT_OPEN];
    assign both_held = q.db[IN_BTN_A] & q.db[IN_BTN_B];
    assign mute_edge = q.db[IN_MUTE] & ~q.db_prev[IN_MUTE];
    assign rst_edge = q.db[IN_RESET] & ~q.db_prev[IN_RESET];
    assign rst_ok = rst_edge & ~fault_cause;

    assign status = {4'h0, q.db[IN_EXT_PRESS], fault_cause, l2_fire,
                     l1_fire, q.phase, q.rel2_fired, q.released,
                     q.lhw_trip, q.fault, q.muted, q.alarm};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic fire_now;
        fire_now = 1'b0;
        d = q;
        d.s1 = raw_in;
        d.s2 = q.s1;
        d.db_prev = q.db;
        d.tick = 1'b0;

        // Free-running time base; every delay counts these ticks
        if (q.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
            d.tick_cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt + 1'b1;
        end

        if (q.tick) begin
            // Input must differ for a full window before it is taken
            for (int i = 0; i < N_IN; i++) begin
                if (q.s2[i] == q.db[i]) begin
                    d.dbc[i] = '0;
                end else if (q.dbc[i] == DB_TICKS - 1'b1) begin
                    d.db[i] = q.s2[i];
                    d.dbc[i] = '0;
                end else begin
                    d.dbc[i] = q.dbc[i] + 1'b1;
                end
            end
            if (q.blink_cnt == BLINK_TICKS - 1'b1) begin
                d.blink_cnt = '0;
                d.blink = ~q.blink;
            end else begin
                d.blink_cnt = q.blink_cnt + 1'b1;
            end
        end

        // Manual hold; any gap in the hold starts it over
        if (both_held) begin
            if (!q.hold_done && q.tick) begin
                if (q.hold == HOLD_TICKS - 1'b1) begin
                    d.hold_done = 1'b1;
                    fire_now = 1'b1;
                end else begin
                    d.hold = q.hold + 1'b1;
                end
            end
        end else begin
            d.hold = '0;
            d.hold_done = 1'b0;
        end
        d.holding = both_held & ~d.hold_done;

        if (q.db[IN_EXT_PRESS] && !q.db[IN_EXT_SHORT]
                && !q.db[IN_EXT_OPEN]) begin
            fire_now = 1'b1;
        end

        // Heat wire keeps fault lit until loop reads normal again
        if (l1_fire) begin
            d.lhw_trip = 1'b1;
        end else if (!q.db[IN_L1_OPEN]) begin
            d.lhw_trip = 1'b0;
        end

        if (rst_ok) begin
            // Fire still present re-latches at once
            d.alarm = any_fire;
            d.fault = 1'b0;
            d.muted = 1'b0;
            d.released = 1'b0;
            d.rel2_fired = 1'b0;
            d.rel2_cnt = '0;
            d.warn = REWARN_TICKS;
            d.phase = (q.cfg.auto_en && rel_fire) ? PH_WARN : PH_IDLE;
        end else begin
            if (any_fire) begin
                d.alarm = 1'b1;
            end
            unique case (q.phase)
                PH_IDLE: begin
                    if (q.cfg.auto_en && rel_fire) begin
                        d.phase = PH_WARN;
                        d.warn = WARN_TICKS;
                    end
                end
                PH_WARN: begin
                    if (q.tick) begin
                        if (q.warn <= 1) begin
                            fire_now = 1'b1;
                        end else begin
                            d.warn = q.warn - 1'b1;
                        end
                    end
                end
                PH_FIRED: begin
                end
            endcase
            if (fire_now) begin
                d.released = 1'b1;
                d.phase = PH_FIRED;
            end
            // Second discharge counts from the main release
            if (q.released && q.cfg.rel2_en && !q.rel2_fired
                    && q.tick) begin
                if (q.rel2_cnt == (q.cfg.rel2_long ? REL2_LONG_TICKS
                                   : REL2_SHORT_TICKS) - 1'b1) begin
                    d.rel2_fired = 1'b1;
                end else begin
                    d.rel2_cnt = q.rel2_cnt + 1'b1;
                end
            end
        end
        // A cause arriving with the reset press still latches
        if (fault_cause) begin
            d.fault = 1'b1;
        end
        // Mute pressed with reset still latches
        if (mute_edge) begin
            d.muted = 1'b1;
        end

        // AHB-Lite: zero wait states, always OKAY
        d.hreadyout = 1'b1;
        d.wr_pend = 1'b0;
        if (q.wr_pend && q.waddr == CTRL_ADDR) begin
            d.cfg = cfg_t'(hwdata[CFG_W-1:0]);
        end
        if (hsel && hready && htrans[1]) begin
            d.wr_pend = hwrite;
            d.waddr = haddr[ADDR_W-1:0];
            d.hrdata = '0;
            if (!hwrite && haddr[ADDR_W-1:0] == CTRL_ADDR) begin
                d.hrdata = {{(32-CFG_W){1'b0}}, q.cfg};
            end else if (!hwrite && haddr[ADDR_W-1:0] == STATUS_ADDR) begin
                d.hrdata = {16'h0000, status};
            end
        end

        // Outputs follow the next state so they move with it
        d.outs.alarm_led = d.alarm;
        d.outs.activated_led = d.released;
        d.outs.fault_led = d.fault | d.lhw_trip;
        d.outs.release1 = d.released;
        d.outs.shutdown = d.cfg.rel2_en ? d.rel2_fired
                          : (d.cfg.auto_en & d.alarm);
        d.outs.sounder = ~d.muted & ((d.alarm & ~d.released)
                         | (d.released & d.blink));
        if (d.holding) begin
            d.outs.buzzer = d.blink;
        end else if (d.hold_done) begin
            d.outs.buzzer = 1'b1;
        end else if (d.muted) begin
            d.outs.buzzer = 1'b0;
        end else if (d.fault || d.lhw_trip) begin
            d.outs.buzzer = 1'b1;
        end else if (d.released) begin
            d.outs.buzzer = d.blink;
        end else begin
            d.outs.buzzer = d.alarm;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.cfg <= CFG_RESET;
            q.hreadyout <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hrdata = q.hrdata;
    assign hreadyout = q.hreadyout;
    assign hresp = q.hresp;
    assign alarm_led = q.outs.alarm_led;
    assign activated_led = q.outs.activated_led;
    assign fault_led = q.outs.fault_led;
    assign buzzer = q.outs.buzzer;
    assign sounder = q.outs.sounder;
    assign shutdown = q.outs.shutdown;
    assign release_out = q.outs.release1;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    auto_release_a: assert property (
        q.phase == PH_WARN && q.warn == 1 && q.tick && !rst_ok
        |=> q.released && release_out)
        else $error("warning expiry did not release");

    hold_abort_a: assert property (
        q.hold != 0 && !both_held |=> q.hold == 0 && !q.hold_done)
        else $error("hold not aborted on button release");

    hold_fire_a: assert property (
        both_held && !q.hold_done && q.tick && q.hold == HOLD_TICKS - 1
        && !rst_ok
        |=> q.released ##1 ($stable(q.released) || $past(rst_ok)))
        else $error("completed hold did not release");

    shutdown_auto_a: assert property (
        !q.cfg.rel2_en && q.cfg.auto_en && $rose(q.alarm)
        |-> shutdown && alarm_led)
        else $error("shutdown not with alarm");

    rel2_gate_a: assert property (
        q.cfg.rel2_en && !q.rel2_fired && $stable(q.cfg)
        |=> !shutdown || q.rel2_fired)
        else $error("shutdown active in second release mode");

    fault_buzz_a: assert property (
        fault_cause && !q.muted && !both_held && !mute_edge
        |=> fault_led && buzzer)
        else $error("fault not shown");

    reset_block_a: assert property (
        rst_edge && fault_cause && q.alarm |=> q.alarm && q.fault)
        else $error("reset accepted during fault");

    rewarn_a: assert property (
        rst_ok && q.cfg.auto_en && rel_fire
        |=> q.phase == PH_WARN && q.warn == REWARN_TICKS && q.alarm)
        else $error("reset did not restart delay");

    alarm_latch_a: assert property (
        q.alarm && !rst_edge |=> q.alarm && alarm_led)
        else $error("alarm dropped without reset");

    double_knock_a: assert property (
        q.cfg.role == ROLE_DOUBLE && q.phase == PH_IDLE
        && !(l1_fire && l2_fire)
        |=> q.phase != PH_WARN)
        else $error("single loop started release");

    lhw_fault_a: assert property (
        q.lhw_trip |-> fault_led)
        else $error("heat wire fault not lit");

endmodule : suppression_release_sequencer

`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench for the suppression release sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import sequencer_pkg::*;

    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    // Two clocks a tick keeps the long warn and hold counts affordable
    localparam int TK = 2;
    localparam int SETTLE = 100;
    localparam int LIMIT = 125000;
    typedef struct packed {
        logic [3:0] kind;
        logic [31:0] val;
    } note_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [N_IN-1:0] pins;
    outs_t o;
    logic toggled = 1'b0;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 32'h2097;
    note_t notes[$];
    note_t cur;
    int flt[5] = '{IN_L1_OPEN, IN_L2_SHORT, IN_L2_OPEN, IN_EXT_SHORT,
                   IN_EXT_OPEN};
    string nm[10] = '{"hrdata", "alarm_led", "activated_led", "fault_led",
                      "buzzer", "sounder", "shutdown", "release_out",
                      "toggled", "hresp_hreadyout"};

    always #2.5 hclk = ~hclk;

    suppression_release_sequencer #(.TICK_CYCLES(TK)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .loop1_short(pins[IN_L1_SHORT]),
        .loop1_open(pins[IN_L1_OPEN]), .loop2_short(pins[IN_L2_SHORT]),
        .loop2_open(pins[IN_L2_OPEN]), .loop2_fire(pins[IN_L2_FIRE]),
        .ext_short(pins[IN_EXT_SHORT]), .ext_open(pins[IN_EXT_OPEN]),
        .ext_press(pins[IN_EXT_PRESS]), .rel_btn_a(pins[IN_BTN_A]),
        .rel_btn_b(pins[IN_BTN_B]), .mute_button(pins[IN_MUTE]),
        .reset_btn(pins[IN_RESET]), .alarm_led(o.alarm_led),
        .activated_led(o.activated_led), .fault_led(o.fault_led),
        .buzzer(o.buzzer), .sounder(o.sounder), .shutdown(o.shutdown),
        .release_out(o.release1)
    );

    panel_model i_panel (.clk(hclk), .pins(pins));

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    function automatic logic [31:0] obs(input int k);
        if (k == 0) return hrdata;
        if (k == 8) return {31'h0, toggled};
        if (k == 9) return {30'h0, hresp, hreadyout};
        return {31'h0, o[7-k]};
    endfunction : obs

    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    always @(negedge hclk) begin
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            checks++;
            if (obs(cur.kind) !== cur.val) begin
                miscompares++;
                $display("wrong value %s expected %h seen %h",
                         nm[cur.kind], cur.val, obs(cur.kind));
            end
        end
    end

    always @(posedge hclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Bus and panel tasks
    // ------------------------------------------------------------
    task automatic note(input int k, input logic [31:0] v);
        notes.push_back(note_t'({k[3:0], v}));
    endtask : note

    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask : ahb

    // Read data stands until the next transfer, so the watcher sees it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        note(0, e);
    endtask : rd

    task automatic wait_hi(input int k);
        int n;
        n = 0;
        while (obs(k) !== 32'h1 && n < 400) begin
            @(posedge hclk);
            n++;
        end
    endtask : wait_hi

    // Blink phase is 500 clocks, so a pulsing output must move in 600
    task automatic toggles(input int k, input logic e);
        logic [31:0] f;
        f = obs(k);
        toggled = 1'b0;
        repeat (600) begin
            @(negedge hclk);
            if (obs(k) !== f) toggled = 1'b1;
        end
        @(posedge hclk);
        note(8, {31'h0, e});
    endtask : toggles

    task automatic press(input int idx);
        i_panel.set(idx, 1'b1);
        cyc(SETTLE);
        i_panel.set(idx, 1'b0);
        cyc(SETTLE);
    endtask : press

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [31:0] v;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(CTRL_ADDR, 32'h0);
        note(9, 32'h1);
        v = $random(seed) & 32'h1f;
        ahb(1'b1, CTRL_ADDR, v);
        rd(CTRL_ADDR, v);
        rd(8'h08, 32'h0);
        ahb(1'b1, CTRL_ADDR, 32'h0);
        $display("test registers done");
        foreach (flt[i]) begin
            i_panel.set(flt[i], 1'b1);
            cyc(SETTLE);
            note(3, 1);
            note(4, 1);
            note(1, 0);
            rd(STATUS_ADDR, 32'h404);
            press(IN_RESET);
            note(3, 1);
            i_panel.set(flt[i], 1'b0);
            cyc(SETTLE);
            press(IN_RESET);
            note(3, 0);
        end
        $display("test faults done");
        i_panel.set(IN_L1_SHORT, 1'b1);
        cyc(SETTLE);
        note(1, 1);
        note(3, 1);
        note(7, 0);
        i_panel.set(IN_L1_SHORT, 1'b0);
        i_panel.set(IN_L1_OPEN, 1'b1);
        cyc(SETTLE);
        press(IN_RESET);
        note(1, 1);
        note(3, 1);
        i_panel.set(IN_L1_OPEN, 1'b0);
        cyc(SETTLE);
        press(IN_RESET);
        note(1, 0);
        note(3, 0);
        $display("test heat wire done");
        i_panel.set(IN_BTN_A, 1'b1);
        i_panel.set(IN_BTN_B, 1'b1);
        cyc(SETTLE);
        toggles(4, 1'b1);
        cyc(TK * ($random(seed) & 32'h1ff));
        i_panel.set(IN_BTN_A, 1'b0);
        cyc(SETTLE);
        note(7, 0);
        i_panel.set(IN_BTN_A, 1'b1);
        cyc(TK * (HOLD_TICKS - 50));
        note(7, 0);
        wait_hi(7);
        note(7, 1);
        note(4, 1);
        toggles(4, 1'b0);
        i_panel.set(IN_BTN_A, 1'b0);
        i_panel.set(IN_BTN_B, 1'b0);
        cyc(SETTLE);
        note(2, 1);
        toggles(5, 1'b1);
        press(IN_RESET);
        note(7, 0);
        $display("test manual done");
        ahb(1'b1, CTRL_ADDR, 32'h19);
        i_panel.set(IN_L2_FIRE, 1'b1);
        wait_hi(1);
        note(1, 1);
        note(6, 1);
        rd(STATUS_ADDR, 32'h201);
        ahb(1'b1, CTRL_ADDR, 32'h03);
        note(5, 1);
        note(6, 0);
        cyc(TK * (WARN_TICKS - 50));
        note(7, 0);
        wait_hi(7);
        note(7, 1);
        note(2, 1);
        cyc(TK * (REL2_SHORT_TICKS - 50));
        note(6, 0);
        wait_hi(6);
        note(6, 1);
        toggles(5, 1'b1);
        press(IN_MUTE);
        note(5, 0);
        note(1, 1);
        ahb(1'b1, CTRL_ADDR, 32'h01);
        press(IN_RESET);
        note(1, 1);
        note(6, 1);
        note(7, 0);
        cyc(TK * (REWARN_TICKS - 150));
        note(7, 0);
        wait_hi(7);
        note(7, 1);
        i_panel.set(IN_L2_FIRE, 1'b0);
        cyc(SETTLE);
        press(IN_RESET);
        note(1, 0);
        note(6, 0);
        note(7, 0);
        $display("test automatic done");
        cyc(2);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
